// File: hw/tac_defs.svh
// Purpose: Offsets, field positions, reset values and limits of the block.
// Assumes: Byte addresses on an Avalon-MM slave with 32-bit data.
// Notes:   Included by its bare name; definitions only.
`ifndef TAC_DEFS_SVH
`define TAC_DEFS_SVH

`define TAC_ADDR_W          8
`define TAC_OFS_CTRL        8'h00
`define TAC_OFS_CMD         8'h04
`define TAC_OFS_STATUS      8'h08
`define TAC_OFS_ERR         8'h0C
`define TAC_OFS_FREE        8'h10
`define TAC_OFS_NSLOT       8'h14
`define TAC_OFS_DEPTH       8'h18
`define TAC_OFS_DEPTH_ACT   8'h1C
`define TAC_OFS_LIST        8'h20

`define TAC_CTRL_CONT_BIT   0
`define TAC_CMD_W           4
`define TAC_CMD_ARM         4'h1
`define TAC_CMD_LIST_DEL    4'h2
`define TAC_CMD_LIST_DEL_Q  4'h3
`define TAC_CMD_INST_RST    4'h4

`define TAC_ERR_ARM         16'hFF2B
`define TAC_ERR_NO_QUERY    16'hFF8F
`define TAC_ERR_RANGE       16'hFF22
`define TAC_ERR_LIST_FULL   16'hFF21

`define TAC_LIST_MAX        8'hC9
`define TAC_DEPTH_W         10
`define TAC_DEPTH_DEF       10'h01E
`define TAC_DEPTH_MIN       10'h00A
`define TAC_DEPTH_MAX       10'h1F4
`define TAC_NSLOT           32'h0000_0001
`define TAC_POOL_BYTES      16'h1400
`define TAC_SETUP_BYTES     16'h0100
`define TAC_CONT_DEF        1'b0

`endif

// File: hw/tac_pkg.sv
// Purpose: Types shared by the trigger and memory control block.
// Assumes: Nothing beyond the header of constants.
// Notes:   Sequencer states are one-hot.
package tac_pkg;
  typedef enum logic [2:0] {
    TAC_IDLE  = 3'b001,
    TAC_ARMED = 3'b010,
    TAC_TRIG  = 3'b100
  } tac_state_e;
endpackage

// File: hw/tac_seq_if.sv
// Purpose: Carries arming, trigger and state between control and sequencer.
// Assumes: One clock for both ends.
// Notes:   None.
`timescale 1ns/1ns
interface tac_seq_if;
  import tac_pkg::*;
  logic       arm;
  logic       cont;
  logic       trig_det;
  logic       done;
  logic       restart;
  logic       fire;
  tac_state_e state;
  modport seq (input arm, cont, trig_det, done, restart,
               output fire, state);
  modport ctl (output arm, cont, trig_det, done, restart,
               input fire, state);
endinterface

// File: hw/tac_list_mem.sv
// Purpose: Storage for the stepped list points.
// Assumes: One write and one read port, same clock.
// Notes:   Read data come out of a register one cycle after the request.
`timescale 1ns/1ns
module tac_list_mem (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        rd_en,
  input  wire logic [7:0]  rd_addr,
  output logic      [31:0] rd_data
);
  logic [31:0] mem [0:255];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// File: hw/tac_seq.sv
// Purpose: Three-state trigger sequencer, Idle, Armed and Triggered.
// Assumes: Arm requests are already checked by the control side.
// Notes:   With continuous arming Idle is left at once.
`timescale 1ns/1ns
module tac_seq
  import tac_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  tac_seq_if.seq   sif
);
  tac_state_e state_reg;
  tac_state_e state_next;

  assign sif.state = state_reg;
  assign sif.fire  = (state_reg == TAC_ARMED) && sif.trig_det;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TAC_IDLE: begin
        if (sif.arm || sif.cont) begin
          state_next = TAC_ARMED;
        end
      end
      TAC_ARMED: begin
        if (sif.trig_det) begin
          state_next = TAC_TRIG;
        end
      end
      TAC_TRIG: begin
        if (sif.done) begin
          state_next = sif.cont ? TAC_ARMED : TAC_IDLE;
        end
      end
      default: state_next = TAC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst || sif.restart) begin
      state_reg <= TAC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// File: hw/tac_trigger_memory_ctrl.sv
// Purpose: Trigger arming and shared-memory bookkeeping behind Avalon-MM.
// Assumes: trig_in is synchronous to clk; srst is the power-on reset.
// Notes:   Each access answers with waitrequest low one cycle after it rises.
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`include "tac_defs.svh"
module tac_trigger_memory_ctrl
  import tac_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        trig_in,
  output logic      [2:0]  seq_state,
  output logic             action_valid,
  output logic      [31:0] action_point,
  output logic             err_flag
);
  tac_seq_if sif ();

  logic        wr_do;
  logic        rd_do;
  logic        rd_load;
  logic        cont_reg;
  logic [15:0] err_code_reg;
  logic [9:0]  depth_pend_reg;
  logic [9:0]  depth_act_reg;
  logic [7:0]  list_count_reg;
  logic [7:0]  step_reg;
  logic        act_pend_reg;
  logic        done_reg;
  logic [31:0] mem_rdata;
  logic [31:0] rdata_next;
  logic [15:0] free_bytes;
  logic        cmd_wr;
  logic [3:0]  cmd_code;
  logic        arm_cmd;
  logic        arm_ok;
  logic        del_cmd;
  logic        delq_cmd;
  logic        inst_rst;
  logic        list_wr;
  logic        list_full;
  logic        depth_wr;
  logic        depth_ok;
  logic        err_set;
  logic [15:0] err_new;
  logic        err_rd;

  // A request is taken at the edge where waitrequest is low.
  assign wr_do   = avs_write && !avs_waitrequest;
  assign rd_do   = avs_read  && !avs_waitrequest;
  // Read data are loaded in the waiting cycle so they stand when taken.
  assign rd_load = avs_read  &&  avs_waitrequest;

  assign cmd_wr   = wr_do && (avs_address == `TAC_OFS_CMD);
  assign cmd_code = avs_writedata[`TAC_CMD_W-1:0];
  assign arm_cmd  = cmd_wr && (cmd_code == `TAC_CMD_ARM);
  assign del_cmd  = cmd_wr && (cmd_code == `TAC_CMD_LIST_DEL);
  assign delq_cmd = cmd_wr && (cmd_code == `TAC_CMD_LIST_DEL_Q);
  // An instrument reset keeps the list and the last error.
  assign inst_rst = cmd_wr && (cmd_code == `TAC_CMD_INST_RST);

  assign arm_ok = (sif.state == TAC_IDLE) && !cont_reg;

  // A point written to a full list is dropped and reported.
  assign list_wr   = wr_do && (avs_address == `TAC_OFS_LIST);
  assign list_full = (list_count_reg >= `TAC_LIST_MAX);

  assign depth_wr = wr_do && (avs_address == `TAC_OFS_DEPTH);
  // Nonzero upper bits are out of range, not silently truncated.
  assign depth_ok = (avs_writedata[31:`TAC_DEPTH_W] == '0) &&
                    (avs_writedata[`TAC_DEPTH_W-1:0] >= `TAC_DEPTH_MIN) &&
                    (avs_writedata[`TAC_DEPTH_W-1:0] <= `TAC_DEPTH_MAX);

  assign err_rd = rd_do && (avs_address == `TAC_OFS_ERR);

  // Error sources, one at a time since one bus access runs per cycle.
  always_comb begin
    err_set = 1'b0;
    err_new = 16'h0000;
    if (arm_cmd && !arm_ok) begin
      err_set = 1'b1;
      err_new = `TAC_ERR_ARM;
    end else if (delq_cmd) begin
      err_set = 1'b1;
      err_new = `TAC_ERR_NO_QUERY;
    end else if (depth_wr && !depth_ok) begin
      err_set = 1'b1;
      err_new = `TAC_ERR_RANGE;
    end else if (list_wr && list_full) begin
      err_set = 1'b1;
      err_new = `TAC_ERR_LIST_FULL;
    end
  end

  // Pool is shared by the setup, the list points and the error queue.
  assign free_bytes = `TAC_POOL_BYTES - `TAC_SETUP_BYTES
                    - {6'h00, list_count_reg, 2'b00}
                    - {6'h00, depth_act_reg};

  assign sif.arm      = arm_cmd && arm_ok;
  assign sif.cont     = cont_reg;
  assign sif.trig_det = trig_in;
  assign sif.done     = done_reg;
  assign sif.restart  = inst_rst;

  tac_seq tac_seq_inst (
    .clk  (clk),
    .srst (srst),
    .sif  (sif)
  );

  // The point of the current step is read as the trigger fires.
  tac_list_mem tac_list_mem_inst (
    .clk     (clk),
    .wr_en   (list_wr && !list_full),
    .wr_addr (list_count_reg),
    .wr_data (avs_writedata),
    .rd_en   (sif.fire),
    .rd_addr (step_reg),
    .rd_data (mem_rdata)
  );

  // Bus handshake: waitrequest drops for one cycle per request.
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address)
      `TAC_OFS_CTRL:      rdata_next = {31'h0, cont_reg};
      `TAC_OFS_STATUS:    rdata_next = {16'h0, list_count_reg, 4'h0,
                                        err_flag, sif.state};
      `TAC_OFS_ERR:       rdata_next = {{16{err_code_reg[15]}},
                                        err_code_reg};
      `TAC_OFS_FREE:      rdata_next = {16'h0, free_bytes};
      `TAC_OFS_NSLOT:     rdata_next = `TAC_NSLOT;
      `TAC_OFS_DEPTH:     rdata_next = {22'h0, depth_pend_reg};
      `TAC_OFS_DEPTH_ACT: rdata_next = {22'h0, depth_act_reg};
      default:            rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_load) begin
      avs_readdata <= rdata_next;
    end
  end

  // Continuous arming; an instrument reset returns it to off.
  always_ff @(posedge clk) begin
    if (srst || inst_rst) begin
      cont_reg <= `TAC_CONT_DEF;
    end else if (wr_do && (avs_address == `TAC_OFS_CTRL)) begin
      cont_reg <= avs_writedata[`TAC_CTRL_CONT_BIT];
    end
  end

  // Error flag; a new error wins over the clearing read.
  always_ff @(posedge clk) begin
    if (srst) begin
      err_flag <= 1'b0;
    end else if (err_set) begin
      err_flag <= 1'b1;
    end else if (err_rd) begin
      err_flag <= 1'b0;
    end
  end

  // Last error code, kept until it is read or replaced.
  always_ff @(posedge clk) begin
    if (srst) begin
      err_code_reg <= 16'h0000;
    end else if (err_set) begin
      err_code_reg <= err_new;
    end else if (err_rd) begin
      err_code_reg <= 16'h0000;
    end
  end

  // Depth setting is held pending until the next instrument reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      depth_pend_reg <= `TAC_DEPTH_DEF;
    end else if (depth_wr && depth_ok) begin
      depth_pend_reg <= avs_writedata[`TAC_DEPTH_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      depth_act_reg <= `TAC_DEPTH_DEF;
    end else if (inst_rst) begin
      depth_act_reg <= depth_pend_reg;
    end
  end

  // Point count; the host clears the list before loading a new one.
  always_ff @(posedge clk) begin
    if (srst || del_cmd) begin
      list_count_reg <= 8'h00;
    end else if (list_wr && !list_full) begin
      list_count_reg <= list_count_reg + 8'h01;
    end
  end

  // Step index advances once per trigger and wraps at the list end.
  always_ff @(posedge clk) begin
    if (srst || del_cmd || inst_rst) begin
      step_reg <= 8'h00;
    end else if (sif.fire) begin
      if (step_reg + 8'h01 >= list_count_reg) begin
        step_reg <= 8'h00;
      end else begin
        step_reg <= step_reg + 8'h01;
      end
    end
  end

  // A fire starts the action; the point data arrive one cycle later.
  always_ff @(posedge clk) begin
    if (srst || inst_rst) begin
      act_pend_reg <= 1'b0;
    end else begin
      act_pend_reg <= sif.fire;
    end
  end

  // Triggered is released once the point has been applied.
  always_ff @(posedge clk) begin
    if (srst || inst_rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= act_pend_reg;
    end
  end

  // An empty list applies no point, so no action pulse is given.
  always_ff @(posedge clk) begin
    if (srst || inst_rst) begin
      action_valid <= 1'b0;
    end else begin
      action_valid <= act_pend_reg && (list_count_reg != 8'h00);
    end
  end

  // The applied point stays on the output until the next action or an instrument reset.
  always_ff @(posedge clk) begin
    if (srst || inst_rst) begin
      action_point <= 32'h0000_0000;
    end else if (act_pend_reg && (list_count_reg != 8'h00)) begin
      action_point <= mem_rdata;
    end
  end

  // The state output is registered, so it lags the sequencer by a cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      seq_state <= TAC_IDLE;
    end else begin
      seq_state <= sif.state;
    end
  end
endmodule

// File: sim/tac_props.sv
// Purpose: Port assertions for the trigger and memory control block.
// Assumes: Ports exactly as the top module declares them.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ns
`include "tac_defs.svh"
module tac_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  seq_state,
  input wire logic        action_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire rd_ok;
  assign rd_ok = avs_read && !avs_waitrequest;
  sequence trig_two;
    seq_state == 3'b100 [*2];
  endsequence
  sequence trig_gone;
    seq_state != 3'b100;
  endsequence
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");
  chk_wait_rest: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low with no request");
  chk_state_onehot: assert property ($onehot(seq_state))
    else $error("sequencer state not one of three");
  chk_reset_idle: assert property (disable iff (1'b0) srst |=>
    seq_state == 3'b001 && avs_waitrequest && !action_valid)
    else $error("reset does not give idle");
  chk_action_armed: assert property (action_valid |->
    seq_state == 3'b100 && $past(seq_state) == 3'b010)
    else $error("action without trigger from armed");
  chk_trig_span: assert property ($rose(seq_state == 3'b100) |->
    trig_two ##1 trig_gone)
    else $error("triggered state length wrong");
  chk_idle_no_trig: assert property (seq_state == 3'b001 |=>
    seq_state != 3'b100)
    else $error("idle went straight to triggered");
  chk_nslot_one: assert property (rd_ok &&
    avs_address == `TAC_OFS_NSLOT |-> avs_readdata == `TAC_NSLOT)
    else $error("slot count not one");
  chk_unmapped_zero: assert property (rd_ok && avs_address >= 8'h24 |->
    avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_depth_range: assert property (rd_ok &&
    (avs_address == `TAC_OFS_DEPTH || avs_address == `TAC_OFS_DEPTH_ACT)
    |-> avs_readdata inside {[10:500]})
    else $error("queue depth out of range");
endmodule
bind tac_trigger_memory_ctrl tac_props tac_props_inst (.clk, .srst,
  .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .seq_state,
  .action_valid);

// File: sim/tac_host.sv
// Purpose: Remote host model, an Avalon-MM master issuing commands.
// Assumes: One request at a time, started right after a rising edge.
// Notes:   A request that is never answered ends the run.
`timescale 1ns/1ns
`include "tac_defs.svh"
module tac_host (
  input  wire logic        clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
      trigger_arm_and_memory_control_bench.hang();
    @(posedge clk);
  endtask
  task automatic new_list(input int cnt, input logic [31:0] base);
    logic [31:0] q;
    xfer(1'b1, `TAC_OFS_CMD, 32'(`TAC_CMD_LIST_DEL), q);
    for (int i = 0; i < cnt; i++)
      xfer(1'b1, `TAC_OFS_LIST, base + 32'(i), q);
  endtask
endmodule

// File: sim/trigger_arm_and_memory_control_bench.sv
// Purpose: Self-checking bench for trigger arming and memory bookkeeping.
// Assumes: Host model drives the register bus, bench drives trig_in.
// Notes:   Expected values follow from the header constants.
`timescale 1ns/1ns
`include "tac_defs.svh"
module trigger_arm_and_memory_control_bench;
  localparam logic [7:0] CT = `TAC_OFS_CTRL;
  localparam logic [7:0] CM = `TAC_OFS_CMD;
  localparam logic [7:0] ST = `TAC_OFS_STATUS;
  localparam logic [7:0] ER = `TAC_OFS_ERR;
  localparam logic [7:0] FE = `TAC_OFS_FREE;
  localparam logic [7:0] DP = `TAC_OFS_DEPTH;
  localparam logic [7:0] DA = `TAC_OFS_DEPTH_ACT;
  localparam logic [31:0] FR = `TAC_POOL_BYTES - `TAC_SETUP_BYTES;
  logic clk, srst, trig_in, avs_read, avs_write, avs_waitrequest;
  logic action_valid, err_flag, got;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, action_point, q, pt;
  logic [2:0]  seq_state;
  int          error_cnt, samples_checked;
  tac_trigger_memory_ctrl tac_trigger_memory_ctrl_inst (.clk, .srst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .trig_in, .seq_state, .action_valid, .action_point,
    .err_flag);
  tac_host tac_host_inst (.clk, .avs_readdata, .avs_waitrequest,
    .avs_address, .avs_read, .avs_write, .avs_writedata);
  initial clk = 1'b0;
  always #5 clk = ~clk;
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tac_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    tac_host_inst.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // One-cycle trigger, then watch a few cycles for the applied point.
  task automatic pulse;
    got = 1'b0;
    pt = 32'h0;
    trig_in <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      if (action_valid === 1'b1) begin
        got = 1'b1;
        pt = action_point;
      end
    end
  endtask
  task automatic t_reset;
    chk(32'(seq_state), 32'h1);
    rdc(CT, 32'h0);
    rdc(ST, 32'h1);
    rdc(`TAC_OFS_NSLOT, 32'h1);
    rdc(DP, 32'd30);
    rdc(DA, 32'd30);
    rdc(FE, FR - 32'd30);
    rdc(8'h40, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_list;
    tac_host_inst.new_list(3, 32'hA0);
    rdc(ST, 32'h0301);
    rdc(FE, FR - 32'd42);
    wr(CM, 32'(`TAC_CMD_LIST_DEL_Q));
    rdc(ER, {16'hFFFF, `TAC_ERR_NO_QUERY});
    rdc(ST, 32'h0301);
    tac_host_inst.new_list(201, 32'h0);
    wr(8'h20, 32'h77);
    rdc(ER, {16'hFFFF, `TAC_ERR_LIST_FULL});
    rdc(ST, 32'hC901);
    rdc(FE, FR - 32'd834);
    wr(CM, 32'(`TAC_CMD_LIST_DEL));
    rdc(ST, 32'h1);
    rdc(FE, FR - 32'd30);
    tac_host_inst.new_list(2, 32'h55);
    $display("t_list done");
  endtask
  task automatic t_trig;
    pulse();
    chk(32'(got), 32'h0);
    wr(CM, 32'(`TAC_CMD_ARM));
    rdc(ST, 32'h0202);
    wr(CM, 32'(`TAC_CMD_ARM));
    chk(32'(err_flag), 32'h1);
    rdc(ER, {16'hFFFF, `TAC_ERR_ARM});
    rdc(ST, 32'h0202);
    pulse();
    chk(pt, 32'h55);
    rdc(ST, 32'h0201);
    $display("t_trig done");
  endtask
  task automatic t_cont;
    wr(CT, 32'h1);
    rdc(CT, 32'h1);
    rdc(ST, 32'h0202);
    wr(CM, 32'(`TAC_CMD_ARM));
    rdc(ER, {16'hFFFF, `TAC_ERR_ARM});
    pulse();
    chk(pt, 32'h56);
    rdc(ST, 32'h0202);
    wr(CT, 32'h0);
    rdc(CT, 32'h0);
    $display("t_cont done");
  endtask
  task automatic t_depth;
    logic [31:0] bad [2];
    bad = '{32'd9, 32'd501};
    wr(DP, 32'd500);
    rdc(DP, 32'd500);
    rdc(DA, 32'd30);
    foreach (bad[i]) begin
      wr(DP, bad[i]);
      rdc(ER, {16'hFFFF, `TAC_ERR_RANGE});
      rdc(DP, 32'd500);
    end
    wr(DP, 32'd10);
    wr(CM, 32'(`TAC_CMD_INST_RST));
    rdc(DA, 32'd10);
    rdc(FE, FR - 32'd18);
    rdc(ST, 32'h0201);
    $display("t_depth done");
  endtask
  initial begin
    srst = 1'b1;
    trig_in = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_list();
    t_trig();
    t_cont();
    t_depth();
    give_verdict();
  end
endmodule
